// ==== core/dpw_pkg.sv ====
// constants shared by the dual pulse generator and its channels
// assumes byte-addressed apb with 32-bit data, 8-bit registers in low bits
package dpw_pkg;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          REG_W        = 8;
    localparam int          DUTY_W       = 10;
    localparam int          PER_W        = 8;
    localparam int          PRE_W        = 6;
    localparam int          IRQ_W        = 7;

    // register byte addresses
    localparam logic [7:0]  ADDR_MASK    = 8'h00;
    localparam logic [7:0]  ADDR_CTRL    = 8'h04;
    localparam logic [7:0]  ADDR_DLO_A   = 8'h08;
    localparam logic [7:0]  ADDR_DHI_A   = 8'h0c;
    localparam logic [7:0]  ADDR_PER_A   = 8'h10;
    localparam logic [7:0]  ADDR_DLO_B   = 8'h14;
    localparam logic [7:0]  ADDR_DHI_B   = 8'h18;
    localparam logic [7:0]  ADDR_PER_B   = 8'h1c;
    localparam logic [7:0]  ADDR_LLO_A   = 8'h20;
    localparam logic [7:0]  ADDR_LHI_A   = 8'h24;
    localparam logic [7:0]  ADDR_LLO_B   = 8'h28;
    localparam logic [7:0]  ADDR_LHI_B   = 8'h2c;
    localparam logic [7:0]  ADDR_STATUS  = 8'h30;
    localparam logic [7:0]  ADDR_GLOBAL  = 8'h34;

    // pulse_control fields
    localparam int          CTL_CHB_EN   = 7;
    localparam int          CTL_CHA_EN   = 6;
    localparam int          CTL_TMB_EN   = 5;
    localparam int          CTL_TMA_EN   = 4;
    localparam int          CTL_PREB_LO  = 2;
    localparam int          CTL_PREA_LO  = 0;

    // interrupt bit positions
    localparam int          IRQ_CHB      = 5;
    localparam int          IRQ_CHA      = 4;

    // duty-high register: writable bits (bit 2 reserved)
    localparam logic [7:0]  DHI_WMASK    = 8'hfb;
    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam logic [6:0]  RST_IRQ      = 7'h00;

    // prescale terminal counts (divide minus one)
    localparam logic [5:0]  PRE_DIV2     = 6'h01;
    localparam logic [5:0]  PRE_DIV8     = 6'h07;
    localparam logic [5:0]  PRE_DIV32    = 6'h1f;
    localparam logic [5:0]  PRE_DIV64    = 6'h3f;
endpackage : dpw_pkg

// ==== core/dpw_sync.sv ====
// two-stage synchroniser with asynchronous clear
// assumes the first stage is read only by the second
`timescale 1ns/100ps
module dpw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,     // destination clock
    input  wire logic             clrN,    // async clear, active low
    input  wire logic [WIDTH-1:0] d,       // asynchronous level
    output logic      [WIDTH-1:0] q        // synchronised level
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge clrN) begin
        if (!clrN) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : dpw_sync

// ==== core/dpw_channel.sv ====
// one pulse channel: prescaler, timer, duty latch and period match
// assumes the same clock and synchronised reset as the register block
`timescale 1ns/100ps
module dpw_channel #(
    parameter int DUTY_W = dpw_pkg::DUTY_W,
    parameter int PER_W  = dpw_pkg::PER_W
) (
    input  wire logic              clk,       // system clock
    input  wire logic              rstN,      // synchronised reset, active low
    input  wire logic              ce,        // clock enable
    input  wire logic              run,       // timer enable
    input  wire logic [1:0]        prescale,  // divider code
    input  wire logic [DUTY_W-1:0] duty,      // programmed duty
    input  wire logic [PER_W-1:0]  period,    // programmed period
    output logic                   level,     // waveform
    output logic [DUTY_W-1:0]      latch,     // latched duty
    output logic                   hit        // period match pulse
);
    typedef struct packed {
        logic [dpw_pkg::PRE_W-1:0] pre;
        logic [DUTY_W-1:0]         timer;
        logic [DUTY_W-1:0]         latch;
        logic                      level;
        logic                      hit;
    } dpw_chan_st_t;

    dpw_chan_st_t st;
    dpw_chan_st_t next_st;
    logic [dpw_pkg::PRE_W-1:0] terminal;

    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;
        case (prescale)                                   // [R3] [R4]
            2'b00:   terminal = dpw_pkg::PRE_DIV2;
            2'b01:   terminal = dpw_pkg::PRE_DIV8;
            2'b10:   terminal = dpw_pkg::PRE_DIV32;
            default: terminal = dpw_pkg::PRE_DIV64;
        endcase
        if (run) begin                                    // [R2]
            if (st.pre >= terminal) begin                 // [R17]
                next_st.pre = '0;
                if (st.timer == DUTY_W'(period)) begin    // [R7] [R8] [R16]
                    next_st.timer = '0;
                    next_st.latch = duty;
                    next_st.level = (duty != '0);
                    next_st.hit   = 1'b1;                 // [R14]
                end else begin
                    next_st.timer = st.timer + 1'b1;
                    if (st.timer + 1'b1 == st.latch) begin
                        next_st.level = 1'b0;             // [R5] [R6] [R17]
                    end
                end
            end else begin
                next_st.pre = st.pre + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign latch = st.latch;
    assign hit   = st.hit;
endmodule : dpw_channel

// ==== core/dpw_top.sv ====
// dual pulse generator with interrupt mask, status and global enable
// assumes an apb master on clk_sys and event pulses from same-clock logic
//
// Contract
// R1: channel enable off leaves pin to port; on drives pin as output.
// R2: each timer runs only while its timer enable is one; default zero.
// R3: second prescale code 00..11 divides by 2, 8, 32, 64; default 00.
// R4: first prescale in low control bits, same encoding, default divide by 2.
// R5: first output high from period start until timer equals its duty.
// R6: second output high until its timer equals its duty.
// R7: first period register sets first channel time base.
// R8: second period register sets second channel time base.
// R9: duty-high registers also hold calibration enable, polarity, 3-bit offset.
// R10: four duty-latch registers are read-only; writes do nothing.
// R11: each interrupt enabled by its mask bit; mask bit 7 reads zero.
// R12: global enable on and off instructions gate all interrupts.
// R13: mask bits: comparator, chan b, chan a, conversion, ext, port, overflow.
// R14: channel flag set on period match, held until software clears.
// R15: status read returns flags anded with mask.
// R16: period match restarts timer, raises output, reloads duty latch; output stays low if the new duty is zero.
// R17: timer counts prescaled ticks; output low from duty match to period end.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module dpw_top (
    input  wire logic                            clk_sys,     // 20 MHz clock
    input  wire logic                            rstn,        // async reset, low
    input  wire logic                            ce,          // clock enable
    input  wire logic                            psel,        // apb select
    input  wire logic                            penable,     // apb enable
    input  wire logic                            pwrite,      // apb write
    input  wire logic [dpw_pkg::ADDR_W-1:0]      paddr,       // apb address
    input  wire logic [dpw_pkg::DATA_W-1:0]      pwdata,      // apb write data
    output logic                                 pready,      // apb ready
    output logic                                 pslverr,     // apb error
    output logic      [dpw_pkg::DATA_W-1:0]      prdata,      // apb read data
    input  wire logic [dpw_pkg::IRQ_W-1:0]       eventIn,     // other flag sets
    input  wire logic [1:0]                      portOut,     // port data a,b
    input  wire logic [1:0]                      portOe,      // port dir a,b
    output logic      [1:0]                      pinOut,      // shared pin data
    output logic      [1:0]                      pinOe,       // shared pin enable
    output logic                                 irqRequest   // gated interrupt
);
    localparam int RW = dpw_pkg::REG_W;
    localparam int IW = dpw_pkg::IRQ_W;
    localparam int DW = dpw_pkg::DUTY_W;

    typedef struct packed {
        logic [IW-1:0]                 mask;
        logic [RW-1:0]                 ctrl;
        logic [RW-1:0]                 dutyLoA;
        logic [RW-1:0]                 dutyHiA;
        logic [RW-1:0]                 periodA;
        logic [RW-1:0]                 dutyLoB;
        logic [RW-1:0]                 dutyHiB;
        logic [RW-1:0]                 periodB;
        logic [IW-1:0]                 flags;
        logic                          globalOn;
        logic                          pready;
        logic                          pslverr;
        logic [dpw_pkg::DATA_W-1:0]    prdata;
        logic [1:0]                    pinOut;
        logic [1:0]                    pinOe;
        logic                          irq;
    } dpw_top_st_t;

    dpw_top_st_t st;
    dpw_top_st_t next_st;

    logic          rstSync;
    logic          levelA;
    logic          levelB;
    logic [DW-1:0] latchA;
    logic [DW-1:0] latchB;
    logic          hitA;
    logic          hitB;
    logic          accessNow;
    logic          doWrite;
    logic          mapped;
    logic [RW-1:0] rdByte;
    logic [RW-1:0] wByte;
    logic [IW-1:0] setMask;
    logic [IW-1:0] clrMask;
    logic [IW-1:0] next_flags;

    // reset release through two flops
    dpw_sync #(
        .WIDTH (1)
    ) u_rst_sync (
        .clk   (clk_sys),
        .clrN  (rstn),
        .d     (1'b1),
        .q     (rstSync)
    );

    dpw_channel #(
        .DUTY_W   (dpw_pkg::DUTY_W),
        .PER_W    (dpw_pkg::PER_W)
    ) u_chan_a (
        .clk      (clk_sys),
        .rstN     (rstSync),
        .ce       (ce),
        .run      (st.ctrl[dpw_pkg::CTL_TMA_EN]),                      // [R2]
        .prescale (st.ctrl[dpw_pkg::CTL_PREA_LO +: 2]),                // [R4]
        .duty     ({st.dutyHiA[1:0], st.dutyLoA}),                     // [R5]
        .period   (st.periodA),                                        // [R7]
        .level    (levelA),
        .latch    (latchA),
        .hit      (hitA)
    );

    dpw_channel #(
        .DUTY_W   (dpw_pkg::DUTY_W),
        .PER_W    (dpw_pkg::PER_W)
    ) u_chan_b (
        .clk      (clk_sys),
        .rstN     (rstSync),
        .ce       (ce),
        .run      (st.ctrl[dpw_pkg::CTL_TMB_EN]),                      // [R2]
        .prescale (st.ctrl[dpw_pkg::CTL_PREB_LO +: 2]),                // [R3]
        .duty     ({st.dutyHiB[1:0], st.dutyLoB}),                     // [R6]
        .period   (st.periodB),                                        // [R8]
        .level    (levelB),
        .latch    (latchB),
        .hit      (hitB)
    );

    // apb handshake: one wait cycle, answer in the second access cycle
    assign accessNow = psel & penable & ~st.pready;
    assign doWrite   = psel & penable & st.pready & pwrite;
    assign wByte     = pwdata[RW-1:0];

    // read decode
    always_comb begin
        mapped = 1'b1;
        rdByte = '0;
        if (paddr == dpw_pkg::ADDR_MASK) begin
            rdByte = {1'b0, st.mask};                                  // [R11]
        end else if (paddr == dpw_pkg::ADDR_CTRL) begin
            rdByte = st.ctrl;
        end else if (paddr == dpw_pkg::ADDR_DLO_A) begin
            rdByte = st.dutyLoA;
        end else if (paddr == dpw_pkg::ADDR_DHI_A) begin
            rdByte = st.dutyHiA;
        end else if (paddr == dpw_pkg::ADDR_PER_A) begin
            rdByte = st.periodA;
        end else if (paddr == dpw_pkg::ADDR_DLO_B) begin
            rdByte = st.dutyLoB;
        end else if (paddr == dpw_pkg::ADDR_DHI_B) begin
            rdByte = st.dutyHiB;
        end else if (paddr == dpw_pkg::ADDR_PER_B) begin
            rdByte = st.periodB;
        end else if (paddr == dpw_pkg::ADDR_LLO_A) begin
            rdByte = latchA[RW-1:0];
        end else if (paddr == dpw_pkg::ADDR_LHI_A) begin
            rdByte = {6'h00, latchA[DW-1:RW]};
        end else if (paddr == dpw_pkg::ADDR_LLO_B) begin
            rdByte = latchB[RW-1:0];
        end else if (paddr == dpw_pkg::ADDR_LHI_B) begin
            rdByte = {6'h00, latchB[DW-1:RW]};
        end else if (paddr == dpw_pkg::ADDR_STATUS) begin
            rdByte = {1'b0, st.flags & st.mask};                       // [R15]
        end else if (paddr == dpw_pkg::ADDR_GLOBAL) begin
            rdByte = {7'h00, st.globalOn};
        end else begin
            mapped = 1'b0;
        end
    end

    // flag set and clear; a set in the clearing cycle wins
    always_comb begin
        setMask = eventIn;
        setMask[dpw_pkg::IRQ_CHA] = hitA | eventIn[dpw_pkg::IRQ_CHA];  // [R14]
        setMask[dpw_pkg::IRQ_CHB] = hitB | eventIn[dpw_pkg::IRQ_CHB];  // [R14]
        clrMask = '0;
        if (doWrite && paddr == dpw_pkg::ADDR_STATUS) begin
            clrMask = wByte[IW-1:0];
        end
        next_flags = (st.flags & ~clrMask) | setMask;                  // [R14]
    end

    always_comb begin
        next_st         = st;
        next_st.flags   = next_flags;
        next_st.pready  = accessNow;
        next_st.pslverr = accessNow & ~mapped;
        if (accessNow && !pwrite) begin
            next_st.prdata = {24'h000000, rdByte};
        end

        if (doWrite) begin
            if (paddr == dpw_pkg::ADDR_MASK) begin
                next_st.mask = wByte[IW-1:0];                          // [R11] [R13]
            end else if (paddr == dpw_pkg::ADDR_CTRL) begin
                next_st.ctrl = wByte;
            end else if (paddr == dpw_pkg::ADDR_DLO_A) begin
                next_st.dutyLoA = wByte;
            end else if (paddr == dpw_pkg::ADDR_DHI_A) begin
                next_st.dutyHiA = wByte & dpw_pkg::DHI_WMASK;          // [R9]
            end else if (paddr == dpw_pkg::ADDR_PER_A) begin
                next_st.periodA = wByte;
            end else if (paddr == dpw_pkg::ADDR_DLO_B) begin
                next_st.dutyLoB = wByte;
            end else if (paddr == dpw_pkg::ADDR_DHI_B) begin
                next_st.dutyHiB = wByte & dpw_pkg::DHI_WMASK;          // [R9]
            end else if (paddr == dpw_pkg::ADDR_PER_B) begin
                next_st.periodB = wByte;
            end else if (paddr == dpw_pkg::ADDR_GLOBAL) begin
                next_st.globalOn = wByte[0];                           // [R12]
            end
            // latch registers take no write                           [R10]
        end

        // shared pins: port owns them unless the channel is enabled
        if (st.ctrl[dpw_pkg::CTL_CHA_EN]) begin
            next_st.pinOut[0] = levelA;                                // [R1]
            next_st.pinOe[0]  = 1'b1;                                  // [R1]
        end else begin
            next_st.pinOut[0] = portOut[0];                            // [R1]
            next_st.pinOe[0]  = portOe[0];
        end
        if (st.ctrl[dpw_pkg::CTL_CHB_EN]) begin
            next_st.pinOut[1] = levelB;                                // [R1]
            next_st.pinOe[1]  = 1'b1;                                  // [R1]
        end else begin
            next_st.pinOut[1] = portOut[1];                            // [R1]
            next_st.pinOe[1]  = portOe[1];
        end

        next_st.irq = st.globalOn & (|(st.flags & st.mask));           // [R11] [R12]
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            st          <= '0;
            st.mask     <= dpw_pkg::RST_IRQ;
            st.flags    <= dpw_pkg::RST_IRQ;
            st.ctrl     <= dpw_pkg::RST_REG;                           // [R2]
            st.dutyLoA  <= dpw_pkg::RST_REG;
            st.dutyHiA  <= dpw_pkg::RST_REG;
            st.periodA  <= dpw_pkg::RST_REG;
            st.dutyLoB  <= dpw_pkg::RST_REG;
            st.dutyHiB  <= dpw_pkg::RST_REG;
            st.periodB  <= dpw_pkg::RST_REG;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pready     = st.pready;
    assign pslverr    = st.pslverr;
    assign prdata     = st.prdata;
    assign pinOut     = st.pinOut;
    assign pinOe      = st.pinOe;
    assign irqRequest = st.irq;
endmodule : dpw_top

// ==== bench/dpw_top_chk.sv ====
// concurrent checks on the dual pulse generator ports
// assumes an apb master that follows the contract; ce low may stall it
`timescale 1ns/100ps
module dpw_top_chk (
    input wire logic        clk_sys,    // clock
    input wire logic        rstn,       // async reset, low
    input wire logic        ce,         // clock enable
    input wire logic        psel,       // apb select
    input wire logic        penable,    // apb enable
    input wire logic        pwrite,     // apb write
    input wire logic [7:0]  paddr,      // apb address
    input wire logic [31:0] pwdata,     // apb write data
    input wire logic        pready,     // apb ready
    input wire logic        pslverr,    // apb error
    input wire logic [31:0] prdata,     // apb read data
    input wire logic [1:0]  portOut,    // port data
    input wire logic [1:0]  portOe,     // port direction
    input wire logic [1:0]  pinOut,     // pin data
    input wire logic [1:0]  pinOe,      // pin enable
    input wire logic        irqRequest  // gated interrupt
);
    logic       wr;
    logic [7:0] shCtl;
    logic [6:0] shMask;
    logic       shGlb;
    assign wr = psel && penable && pready && pwrite && ce;
    // shadow copies of the registers that gate outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shCtl  <= 8'h00;
            shMask <= 7'h00;
            shGlb  <= 1'h0;
        end else if (wr) begin
            if (paddr == dpw_pkg::ADDR_CTRL) shCtl <= pwdata[7:0];
            if (paddr == dpw_pkg::ADDR_MASK) shMask <= pwdata[6:0];
            if (paddr == dpw_pkg::ADDR_GLOBAL) shGlb <= pwdata[0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence accStart;
        psel && penable && !pready && ce;
    endsequence
    sequence rdRet;
        pready && !pwrite;
    endsequence
    wait_state_a: assert property (accStart |=> pready) else $error("no answer after wait");
    ready_pulse_a: assert property (pready && ce |=> !pready) else $error("ready held");
    unmapped_err_a: assert property (pready && paddr > dpw_pkg::ADDR_GLOBAL |-> pslverr)
        else $error("unmapped not refused");
    mapped_ok_a: assert property (pready && paddr <= dpw_pkg::ADDR_GLOBAL && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped refused");
    mask_read_a: assert property (rdRet and paddr == dpw_pkg::ADDR_MASK |->
        prdata[7:0] == {1'h0, shMask}) else $error("mask readback wrong");
    ctl_read_a: assert property (rdRet and paddr == dpw_pkg::ADDR_CTRL |->
        prdata[7:0] == shCtl) else $error("control readback wrong");
    upper_zero_a: assert property (rdRet |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    pin_enable_a: assert property (pinOe == ($past(shCtl[7:6]) | $past(portOe)))
        else $error("pin enable wrong");
    port_pass_a: assert property (!$past(shCtl[6]) |-> pinOut[0] == $past(portOut[0]))
        else $error("port data not passed");
    glb_off_a: assert property (!$past(shGlb) |-> !irqRequest) else $error("irq while off");
    mask_off_a: assert property ($past(shMask) == 7'h00 |-> !irqRequest)
        else $error("irq while masked");
endmodule : dpw_top_chk

bind dpw_top dpw_top_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .portOut(portOut), .portOe(portOe),
    .pinOut(pinOut), .pinOe(pinOe), .irqRequest(irqRequest));

// ==== bench/testbench.sv ====
// self-checking bench for the dual pulse generator
// assumes the checker binds itself; ce drops only in the freeze scenario
`timescale 1ns/100ps
module testbench;
    logic        clk_sys     = 1'h0;
    logic        rstn        = 1'h0;
    logic        ce          = 1'h1;
    logic        psel        = 1'h0;
    logic        penable     = 1'h0;
    logic        pwrite      = 1'h0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [6:0]  eventIn     = 7'h00;
    logic [1:0]  portOut     = 2'h0;
    logic [1:0]  portOe      = 2'h0;
    logic        pready;
    logic        pslverr;
    logic        irqRequest;
    logic [31:0] prdata;
    logic [1:0]  pinOut;
    logic [1:0]  pinOe;
    logic [31:0] rd;
    logic        err;
    int          miscompares = 0;
    int          checks      = 0;
    int          divs[4]     = '{2, 8, 32, 64};

    always #25 clk_sys = ~clk_sys;

    dpw_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .eventIn(eventIn),
        .portOut(portOut), .portOe(portOe), .pinOut(pinOut), .pinOe(pinOe),
        .irqRequest(irqRequest));

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word

    task automatic tick(inout int n, input string nm);
        @(posedge clk_sys);
        n++;
        if (n > 2000) begin
            miscompares++;
            $display("unexpected %s expected finish seen stuck", nm);
            give_verdict();
        end
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'h0;
        @(posedge clk_sys);
        penable <= 1'h1;
        do tick(n, "apb"); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk_word(nm, exp, rd);
    endtask : rdc

    task automatic measure(input int ch, output int hi, output int tot);
        int n;
        n = 0;
        hi = 0;
        while (pinOut[ch] !== 1'h0) tick(n, "low");
        while (pinOut[ch] !== 1'h1) tick(n, "rise");
        while (pinOut[ch] === 1'h1) begin
            tick(n, "fall");
            hi++;
        end
        tot = hi;
        while (pinOut[ch] !== 1'h1) begin
            tick(n, "period");
            tot++;
        end
    endtask : measure

    task automatic wait_irq();
        int n;
        n = 0;
        while (irqRequest !== 1'h1) tick(n, "irq");
    endtask : wait_irq

    task automatic t_defaults();
        for (int i = 0; i < 14; i++) rdc("reset value", 8'(4 * i), 32'h0);
        apb(1'h0, 8'h38, 32'h0);
        chk_word("unmapped error", 32'h1, {31'h0, err});
    endtask : t_defaults

    task automatic t_regs();
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'hffffffff);
        rdc("mask", dpw_pkg::ADDR_MASK, 32'h7f);
        apb(1'h1, dpw_pkg::ADDR_DHI_B, 32'hff);
        rdc("duty high b", dpw_pkg::ADDR_DHI_B, 32'hfb);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, dpw_pkg::ADDR_LLO_A + 8'(4 * i), 32'hff);
            rdc("latch", dpw_pkg::ADDR_LLO_A + 8'(4 * i), 32'h0);
        end
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'h0);
    endtask : t_regs

    task automatic t_pins();
        portOe  <= 2'h3;
        portOut <= 2'h2;
        repeat (3) @(posedge clk_sys);
        chk_word("port enable", 32'h3, {30'h0, pinOe});
        chk_word("port data", 32'h2, {30'h0, pinOut});
        portOe <= 2'h0;
        apb(1'h1, dpw_pkg::ADDR_CTRL, 32'hc0);
        repeat (2) @(posedge clk_sys);
        chk_word("channel drive", 32'h3, {30'h0, pinOe});
    endtask : t_pins

    task automatic t_wave();
        int h;
        int t;
        apb(1'h1, dpw_pkg::ADDR_DLO_A, 32'h2);
        apb(1'h1, dpw_pkg::ADDR_DHI_A, 32'hd8);
        apb(1'h1, dpw_pkg::ADDR_PER_A, 32'h3);
        apb(1'h1, dpw_pkg::ADDR_DLO_B, 32'h1);
        apb(1'h1, dpw_pkg::ADDR_DHI_B, 32'h0);
        apb(1'h1, dpw_pkg::ADDR_PER_B, 32'h5);
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, dpw_pkg::ADDR_CTRL, {24'h0, 4'hf, 2'(3 - c), 2'(c)});
            measure(0, h, t);
            measure(0, h, t);
            chk_word("high a", 2 * divs[c], h);
            chk_word("period a", 4 * divs[c], t);
            measure(1, h, t);
            measure(1, h, t);
            chk_word("high b", divs[3 - c], h);
            chk_word("period b", 6 * divs[3 - c], t);
        end
        rdc("latch low a", dpw_pkg::ADDR_LLO_A, 32'h2);
        rdc("latch low b", dpw_pkg::ADDR_LLO_B, 32'h1);
        rdc("duty high a", dpw_pkg::ADDR_DHI_A, 32'hd8);
    endtask : t_wave

    task automatic t_freeze();
        logic [1:0] held;
        int         moves;
        ce <= 1'h0;
        repeat (2) @(posedge clk_sys);
        held  = pinOut;
        moves = 0;
        repeat (30) begin
            @(posedge clk_sys);
            if (pinOut !== held) moves++;
        end
        chk_word("frozen pin changes", 32'h0, moves);
        ce <= 1'h1;
    endtask : t_freeze

    task automatic t_irq();
        int ev[5] = '{0, 1, 2, 3, 6};
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'h10);
        apb(1'h1, dpw_pkg::ADDR_GLOBAL, 32'h1);
        wait_irq();
        rdc("status masked", dpw_pkg::ADDR_STATUS, 32'h10);
        apb(1'h1, dpw_pkg::ADDR_GLOBAL, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk_word("irq global off", 32'h0, {31'h0, irqRequest});
        apb(1'h1, dpw_pkg::ADDR_CTRL, 32'h0);
        apb(1'h1, dpw_pkg::ADDR_STATUS, 32'h7f);
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'h7f);
        repeat (300) @(posedge clk_sys);
        rdc("status stopped", dpw_pkg::ADDR_STATUS, 32'h0);
        foreach (ev[i]) begin
            @(posedge clk_sys);
            eventIn <= 7'h01 << ev[i];
            @(posedge clk_sys);
            eventIn <= 7'h00;
            rdc("event flag", dpw_pkg::ADDR_STATUS, 32'h1 << ev[i]);
            apb(1'h1, dpw_pkg::ADDR_STATUS, 32'h7f);
        end
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'h0);
        apb(1'h1, dpw_pkg::ADDR_GLOBAL, 32'h1);
        eventIn <= 7'h40;
        @(posedge clk_sys);
        eventIn <= 7'h00;
        repeat (4) @(posedge clk_sys);
        chk_word("irq masked", 32'h0, {31'h0, irqRequest});
        apb(1'h1, dpw_pkg::ADDR_MASK, 32'h40);
        wait_irq();
    endtask : t_irq

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'h1;
        repeat (3) @(posedge clk_sys);
        t_defaults();
        t_regs();
        t_pins();
        t_wave();
        t_freeze();
        t_irq();
        give_verdict();
    end
endmodule : testbench
